// ### design/pmc_pkg.sv
package pmc_pkg;

	// Clock and the automatic transfer interval
	localparam int CLOCK_PERIOD_NS = 20;
	localparam int TRANSFER_PERIOD_NS = 1000000000;
	localparam int TRANSFER_PERIOD_CYCLES = TRANSFER_PERIOD_NS / CLOCK_PERIOD_NS;

	localparam int LINK_COUNT = 4;
	localparam int ADDR_WIDTH = 14;

	// Register indexes; the byte address is four times the index
	localparam logic [11:0] ACCESS_SELECT_INDEX = 12'h00e;
	localparam logic [11:0] ACCESS_READ_DATA_INDEX = 12'h00f;
	localparam logic [7:0] UPDATE_CONTROL_INDEX = 8'hc2;
	localparam logic [7:0] OVERFLOW_ENABLE_LOW_INDEX = 8'hc3;
	localparam logic [7:0] OVERFLOW_ENABLE_HIGH_INDEX = 8'hc4;
	localparam logic [7:0] OVERFLOW_FLAGS_LOW_INDEX = 8'hc5;
	localparam logic [7:0] OVERFLOW_FLAGS_HIGH_INDEX = 8'hc6;

	// Field positions
	localparam int MANUAL_TRANSFER_TRIGGER_BIT = 0;
	localparam int AUTO_TRANSFER_ENABLE_BIT = 1;
	localparam int SELECT_INDEX_LSB = 0;
	localparam int SELECT_LINK_LSB = 4;
	localparam int CHECKSUM_OVERFLOW_BIT = 0;
	localparam int FRAMING_BIT_OVERFLOW_BIT = 1;
	localparam int ALIGNMENT_CHANGE_OVERFLOW_BIT = 2;
	localparam int SYNC_LOSS_OVERFLOW_BIT = 3;
	localparam int PATTERN_ERROR_OVERFLOW_BIT = 4;
	localparam int DDS_OVERFLOW_BIT = 5;
	localparam int LINE_CODE_OVERFLOW_BIT = 0;

	// Implemented bits of each register
	localparam logic [7:0] UPDATE_CONTROL_MASK = 8'h03;
	localparam logic [7:0] ACCESS_SELECT_MASK = 8'h3f;
	localparam logic [7:0] LOW_GROUP_MASK = 8'h3f;
	localparam logic [7:0] HIGH_GROUP_MASK = 8'h01;

	// Values after reset
	localparam logic [7:0] UPDATE_CONTROL_RESET = 8'h00;
	localparam logic [7:0] ACCESS_SELECT_RESET = 8'h00;
	localparam logic [7:0] OVERFLOW_ENABLE_RESET = 8'h00;
	localparam logic [7:0] OVERFLOW_FLAGS_RESET = 8'h00;

	// Indirect holding register indexes
	localparam logic [3:0] HOLD_CHECKSUM_LOW = 4'h0;
	localparam logic [3:0] HOLD_CHECKSUM_HIGH = 4'h1;
	localparam logic [3:0] HOLD_FRAMING_LOW = 4'h2;
	localparam logic [3:0] HOLD_FRAMING_HIGH = 4'h3;
	localparam logic [3:0] HOLD_ALIGNMENT = 4'h4;
	localparam logic [3:0] HOLD_SYNC_LOSS = 4'h5;
	localparam logic [3:0] HOLD_PATTERN_LOW = 4'h6;
	localparam logic [3:0] HOLD_PATTERN_HIGH = 4'h7;
	localparam logic [3:0] HOLD_LINE_CODE_LOW = 4'h8;
	localparam logic [3:0] HOLD_LINE_CODE_HIGH = 4'h9;
	localparam logic [3:0] HOLD_DDS_LOW = 4'ha;
	localparam logic [3:0] HOLD_DDS_HIGH = 4'hb;

	// Counter widths
	localparam int LINE_CODE_WIDTH = 16;
	localparam int FRAMING_WIDTH = 12;
	localparam int CHECKSUM_WIDTH = 10;
	localparam int ALIGNMENT_WIDTH = 3;
	localparam int SYNC_LOSS_WIDTH = 5;
	localparam int PATTERN_WIDTH = 16;
	localparam int DDS_WIDTH = 10;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		superframe_format,
		extended_superframe_format,
		digital_data_framing_format,
		subscriber_carrier_framing_format
	} pmc_format_type;

	// One-cycle event pulses from the framer and line decoder of one link
	typedef struct packed {
		logic line_code_error;
		logic framing_bit_error;
		logic checksum_error;
		logic alignment_change;
		logic sync_loss;
		logic pattern_bit_error;
		logic dds_pattern_error;
	} pmc_events_type;

endpackage

// ### design/pmc_performance_monitor.sv
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module pmc_event_counter #(
	parameter int WIDTH = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic count_event,
	input wire logic transfer,
	output logic [WIDTH-1:0] held,
	output logic overflow
);
	logic [WIDTH-1:0] count;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			count <= '0;
		else if (transfer)
			count <= WIDTH'(count_event);
		else if (count_event)
			count <= count + WIDTH'(1);
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			held <= '0;
		else if (transfer)
			held <= count;
	end
	// A wrap during a transfer cycle cannot happen: the event lands in the new interval
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			overflow <= 1'b0;
		else
			overflow <= count_event && !transfer && (&count);
	end
endmodule // pmc_event_counter
module pmc_performance_monitor
	import pmc_pkg::*;
#(
	parameter int SECOND_CYCLES = TRANSFER_PERIOD_CYCLES
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Framer side, one entry per link
	input wire pmc_events_type link_events [LINK_COUNT],
	input wire pmc_format_type framing_format [LINK_COUNT],
	input wire logic [LINK_COUNT-1:0] j1_mode,
	// AXI4-Lite write
	input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Interrupt
	output logic irq
);
	logic [7:0] update_control [LINK_COUNT];
	logic [7:0] enable_low [LINK_COUNT], enable_high [LINK_COUNT];
	logic [7:0] flags_low [LINK_COUNT], flags_high [LINK_COUNT];
	logic [7:0] access_select;
	logic [LINK_COUNT-1:0] trigger_prev, transfer;
	logic [31:0] second_count;
	logic second_tick;
	logic [LINE_CODE_WIDTH-1:0] held_line_code [LINK_COUNT];
	logic [FRAMING_WIDTH-1:0] held_framing [LINK_COUNT];
	logic [CHECKSUM_WIDTH-1:0] held_checksum [LINK_COUNT];
	logic [ALIGNMENT_WIDTH-1:0] held_alignment [LINK_COUNT];
	logic [SYNC_LOSS_WIDTH-1:0] held_sync_loss [LINK_COUNT];
	logic [PATTERN_WIDTH-1:0] held_pattern [LINK_COUNT];
	logic [DDS_WIDTH-1:0] held_dds [LINK_COUNT];
	logic [7:0] overflow_low [LINK_COUNT], overflow_high [LINK_COUNT];
	logic [ADDR_WIDTH-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic aw_full, w_full, do_write, next_rd_ok;
	logic [11:0] wr_index, rd_index;
	logic [7:0] holding_read_value, next_rdata;

	// One shared second strobe for all links
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			second_count <= '0;
			second_tick <= 1'b0;
		end
		else if (second_count >= 32'(SECOND_CYCLES - 1))
		begin
			second_count <= '0;
			second_tick <= 1'b1;
		end
		else
		begin
			second_count <= second_count + 32'h1;
			second_tick <= 1'b0;
		end
	end

	genvar l;
	generate
		for (l = 0; l < LINK_COUNT; l++)
		begin : g_link
			logic is_esf;
			logic is_dm_t1;
			logic manual_edge;
			assign manual_edge = update_control[l][MANUAL_TRANSFER_TRIGGER_BIT]
				&& !trigger_prev[l];
			assign transfer[l] = manual_edge
				|| (update_control[l][AUTO_TRANSFER_ENABLE_BIT] && second_tick);
			assign is_esf = framing_format[l] == extended_superframe_format;
			// Digital-data framing is a T1-only format; in J1 it yields no DDS counts
			assign is_dm_t1 = framing_format[l] == digital_data_framing_format
				&& !j1_mode[l];
			pmc_event_counter #(.WIDTH(LINE_CODE_WIDTH)) u_line_code (
				.aclk(aclk), .aresetn(aresetn), .transfer(transfer[l]),
				.count_event(link_events[l].line_code_error),
				.held(held_line_code[l]), .overflow(overflow_high[l][LINE_CODE_OVERFLOW_BIT]));
			pmc_event_counter #(.WIDTH(FRAMING_WIDTH)) u_framing (
				.aclk(aclk), .aresetn(aresetn), .transfer(transfer[l]),
				.count_event(link_events[l].framing_bit_error),
				.held(held_framing[l]), .overflow(overflow_low[l][FRAMING_BIT_OVERFLOW_BIT]));
			pmc_event_counter #(.WIDTH(CHECKSUM_WIDTH)) u_checksum (
				.aclk(aclk), .aresetn(aresetn), .transfer(transfer[l]),
				.count_event(link_events[l].checksum_error && is_esf),
				.held(held_checksum[l]), .overflow(overflow_low[l][CHECKSUM_OVERFLOW_BIT]));
			pmc_event_counter #(.WIDTH(ALIGNMENT_WIDTH)) u_alignment (
				.aclk(aclk), .aresetn(aresetn), .transfer(transfer[l]),
				.count_event(link_events[l].alignment_change),
				.held(held_alignment[l]),
				.overflow(overflow_low[l][ALIGNMENT_CHANGE_OVERFLOW_BIT]));
			pmc_event_counter #(.WIDTH(SYNC_LOSS_WIDTH)) u_sync_loss (
				.aclk(aclk), .aresetn(aresetn), .transfer(transfer[l]),
				.count_event(link_events[l].sync_loss),
				.held(held_sync_loss[l]), .overflow(overflow_low[l][SYNC_LOSS_OVERFLOW_BIT]));
			pmc_event_counter #(.WIDTH(PATTERN_WIDTH)) u_pattern (
				.aclk(aclk), .aresetn(aresetn), .transfer(transfer[l]),
				.count_event(link_events[l].pattern_bit_error),
				.held(held_pattern[l]), .overflow(overflow_low[l][PATTERN_ERROR_OVERFLOW_BIT]));
			pmc_event_counter #(.WIDTH(DDS_WIDTH)) u_dds (
				.aclk(aclk), .aresetn(aresetn), .transfer(transfer[l]),
				.count_event(link_events[l].dds_pattern_error && is_dm_t1),
				.held(held_dds[l]), .overflow(overflow_low[l][DDS_OVERFLOW_BIT]));
			assign overflow_low[l][7:6] = 2'h0;
			assign overflow_high[l][7:1] = 7'h00;
		end
	endgenerate

	// Write channel: address and data are taken in either order
	assign do_write = aw_full && w_full && !s_axi_bvalid;
	assign wr_index = aw_addr[13:2];
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full <= 1'b0;
			s_axi_awready <= 1'b1;
			aw_addr <= '0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_full <= 1'b1;
			s_axi_awready <= 1'b0;
			aw_addr <= s_axi_awaddr;
		end
		else if (s_axi_bvalid && s_axi_bready)
		begin
			aw_full <= 1'b0;
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_full <= 1'b0;
			s_axi_wready <= 1'b1;
			w_data <= '0;
			w_strb <= '0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_full <= 1'b1;
			s_axi_wready <= 1'b0;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		else if (s_axi_bvalid && s_axi_bready)
		begin
			w_full <= 1'b0;
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			if (wr_index == ACCESS_SELECT_INDEX || wr_index == ACCESS_READ_DATA_INDEX
				|| (wr_index[11:10] == 2'h0 && wr_index[7:0] >= UPDATE_CONTROL_INDEX
				&& wr_index[7:0] <= OVERFLOW_FLAGS_HIGH_INDEX))
				s_axi_bresp <= RESP_OKAY;
			else
				s_axi_bresp <= RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			access_select <= ACCESS_SELECT_RESET;
		else if (do_write && w_strb[0] && wr_index == ACCESS_SELECT_INDEX)
			access_select <= w_data[7:0] & ACCESS_SELECT_MASK;
	end

	// Per-link registers; the link number sits in index bits 9:8
	always_ff @(posedge aclk)
	begin
		for (int i = 0; i < LINK_COUNT; i++)
		begin
			if (!aresetn)
			begin
				update_control[i] <= UPDATE_CONTROL_RESET;
				enable_low[i] <= OVERFLOW_ENABLE_RESET;
				enable_high[i] <= OVERFLOW_ENABLE_RESET;
				trigger_prev[i] <= 1'b0;
			end
			else
			begin
				trigger_prev[i] <= update_control[i][MANUAL_TRANSFER_TRIGGER_BIT];
				if (do_write && w_strb[0] && wr_index[11:10] == 2'h0
					&& wr_index[9:8] == 2'(i))
				begin
					if (wr_index[7:0] == UPDATE_CONTROL_INDEX)
						update_control[i] <= w_data[7:0] & UPDATE_CONTROL_MASK;
					if (wr_index[7:0] == OVERFLOW_ENABLE_LOW_INDEX)
						enable_low[i] <= w_data[7:0] & LOW_GROUP_MASK;
					if (wr_index[7:0] == OVERFLOW_ENABLE_HIGH_INDEX)
						enable_high[i] <= w_data[7:0] & HIGH_GROUP_MASK;
				end
			end
		end
	end

	// Sticky flags, write one to clear; a new overflow beats a clear in the same cycle
	always_ff @(posedge aclk)
	begin
		for (int i = 0; i < LINK_COUNT; i++)
		begin
			if (!aresetn)
			begin
				flags_low[i] <= OVERFLOW_FLAGS_RESET;
				flags_high[i] <= OVERFLOW_FLAGS_RESET;
			end
			else
			begin
				logic hit;
				hit = do_write && w_strb[0] && wr_index[11:10] == 2'h0
					&& wr_index[9:8] == 2'(i);
				flags_low[i] <= (flags_low[i] & ~((hit
					&& wr_index[7:0] == OVERFLOW_FLAGS_LOW_INDEX) ? w_data[7:0] : 8'h00))
					| overflow_low[i];
				flags_high[i] <= (flags_high[i] & ~((hit
					&& wr_index[7:0] == OVERFLOW_FLAGS_HIGH_INDEX) ? w_data[7:0] : 8'h00))
					| overflow_high[i];
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq <= 1'b0;
		else
		begin
			logic any;
			any = 1'b0;
			for (int i = 0; i < LINK_COUNT; i++)
				any = any || |(flags_low[i] & enable_low[i])
					|| |(flags_high[i] & enable_high[i]);
			irq <= any;
		end
	end

	// Indirect holding register chosen by the select register
	always_comb
	begin
		logic [1:0] sl;
		sl = access_select[SELECT_LINK_LSB +: 2];
		unique case (access_select[SELECT_INDEX_LSB +: 4])
			HOLD_CHECKSUM_LOW: holding_read_value = held_checksum[sl][7:0];
			HOLD_CHECKSUM_HIGH: holding_read_value = {6'h00, held_checksum[sl][9:8]};
			HOLD_FRAMING_LOW: holding_read_value = held_framing[sl][7:0];
			HOLD_FRAMING_HIGH: holding_read_value = {4'h0, held_framing[sl][11:8]};
			HOLD_ALIGNMENT: holding_read_value = {5'h00, held_alignment[sl]};
			HOLD_SYNC_LOSS: holding_read_value = {3'h0, held_sync_loss[sl]};
			HOLD_PATTERN_LOW: holding_read_value = held_pattern[sl][7:0];
			HOLD_PATTERN_HIGH: holding_read_value = held_pattern[sl][15:8];
			HOLD_LINE_CODE_LOW: holding_read_value = held_line_code[sl][7:0];
			HOLD_LINE_CODE_HIGH: holding_read_value = held_line_code[sl][15:8];
			HOLD_DDS_LOW: holding_read_value = held_dds[sl][7:0];
			HOLD_DDS_HIGH: holding_read_value = {6'h00, held_dds[sl][9:8]};
			default: holding_read_value = 8'h00;
		endcase
	end

	assign rd_index = s_axi_araddr[13:2];
	always_comb
	begin
		logic [1:0] rl;
		rl = rd_index[9:8];
		next_rd_ok = 1'b1;
		next_rdata = 8'h00;
		if (rd_index == ACCESS_SELECT_INDEX)
			next_rdata = access_select;
		else if (rd_index == ACCESS_READ_DATA_INDEX)
			next_rdata = holding_read_value;
		else if (rd_index[11:10] == 2'h0 && rd_index[7:0] == UPDATE_CONTROL_INDEX)
			next_rdata = update_control[rl];
		else if (rd_index[11:10] == 2'h0 && rd_index[7:0] == OVERFLOW_ENABLE_LOW_INDEX)
			next_rdata = enable_low[rl];
		else if (rd_index[11:10] == 2'h0 && rd_index[7:0] == OVERFLOW_ENABLE_HIGH_INDEX)
			next_rdata = enable_high[rl];
		else if (rd_index[11:10] == 2'h0 && rd_index[7:0] == OVERFLOW_FLAGS_LOW_INDEX)
			next_rdata = flags_low[rl];
		else if (rd_index[11:10] == 2'h0 && rd_index[7:0] == OVERFLOW_FLAGS_HIGH_INDEX)
			next_rdata = flags_high[rl];
		else
			next_rd_ok = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, next_rdata};
			s_axi_rresp <= next_rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule // pmc_performance_monitor

`default_nettype wire

// ### verification/pmc_performance_monitor_checker.sv
`timescale 1ns/1ps
`default_nettype none

module pmc_performance_monitor_checker
	import pmc_pkg::*;
#(
	parameter int SECOND_CYCLES = TRANSFER_PERIOD_CYCLES
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Framer side
	input wire pmc_events_type link_events [LINK_COUNT],
	input wire pmc_format_type framing_format [LINK_COUNT],
	input wire logic [LINK_COUNT-1:0] j1_mode,
	// Write channels
	input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read channels
	input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Interrupt
	input wire logic irq
);
	logic ev_any;

	always_comb
	begin
		ev_any = 1'h0;
		for (int i = 0; i < LINK_COUNT; i++)
		begin
			ev_any = ev_any | (|link_events[i]);
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence

	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	// An interrupt can only start from a counter wrap or a register write
	sequence irq_cause;
		$past(ev_any, 2) || $past(ev_any, 3) || $past(ev_any, 4) || $past(s_axi_bvalid)
			|| $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3);
	endsequence

	rd_answer_a: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer missing");
	rd_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer not released");
	rd_upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	rd_error_data_a: assert property (s_axi_rvalid && s_axi_rresp != RESP_OKAY
		|-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("bad error response");
	wr_answer_a: assert property (wr_take
		|-> ##2 s_axi_bvalid && s_axi_bresp == RESP_OKAY)
		else $error("write answer missing");
	wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	irq_cause_a: assert property ($rose(irq) |-> irq_cause)
		else $error("interrupt without cause");
	irq_drop_a: assert property ($fell(irq) |-> $past(s_axi_bvalid)
		|| $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3))
		else $error("interrupt dropped without write");
endmodule // pmc_performance_monitor_checker

bind pmc_performance_monitor pmc_performance_monitor_checker #(
	.SECOND_CYCLES(SECOND_CYCLES)
) chk_i (.*);

`default_nettype wire

// ### verification/pmc_performance_monitor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module pmc_performance_monitor_tb_top
	import pmc_pkg::*;
;
	localparam int SEC = 50;
	// Event bit positions inside the packed event struct
	localparam int LC = 6, FB = 5, CK = 4, AL = 3, SY = 2, PT = 1, DD = 0;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	pmc_events_type link_events [LINK_COUNT];
	pmc_format_type framing_format [LINK_COUNT];
	logic [LINK_COUNT-1:0] j1_mode = 4'h2;
	logic [ADDR_WIDTH-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
	// Always ready for answers: legal and avoids re-raising in one step
	logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [1:0] wr_resp;
	int error_cnt = 0, checks_done = 0;
	logic [13:0] sel_a, dat_a;

	assign sel_a = {ACCESS_SELECT_INDEX, 2'h0};
	assign dat_a = {ACCESS_READ_DATA_INDEX, 2'h0};

	pmc_performance_monitor #(.SECOND_CYCLES(SEC)) dut (.*);

	initial forever #10 aclk = ~aclk;

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wait_out(input int n);
		if (n >= 40)
		begin
			chk("bus answer", 32'h1, 32'h0);
			finish_test();
		end
	endtask

	task automatic wr(input logic [13:0] a, input logic [7:0] d);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			n++;
		end
		while (!s_axi_bvalid && n < 40);
		wr_resp = s_axi_bresp;
		wait_out(s_axi_bvalid ? 0 : n);
	endtask

	task automatic rd(input logic [13:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			n++;
		end
		while (!s_axi_rvalid && n < 40);
		d = s_axi_rdata;
		r = s_axi_rresp;
		wait_out(s_axi_rvalid ? 0 : n);
	endtask

	function automatic logic [13:0] la(input int l, input logic [7:0] i);
		return {2'h0, l[1:0], i, 2'h0};
	endfunction

	task automatic rchk(input string what, input logic [13:0] a, input logic [7:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(what, {24'h0, exp}, d);
	endtask

	task automatic hchk(input int l, input logic [3:0] i, input logic [7:0] exp);
		wr(sel_a, {2'h0, l[1:0], i});
		rchk("holding", dat_a, exp);
	endtask

	task automatic pulse(input int l, input int b, input int cnt);
		repeat (cnt)
		begin
			@(posedge aclk);
			link_events[l][b] <= 1'h1;
		end
		@(posedge aclk);
		link_events[l][b] <= 1'h0;
	endtask

	task automatic trig(input int l);
		wr(la(l, UPDATE_CONTROL_INDEX), 8'h00);
		wr(la(l, UPDATE_CONTROL_INDEX), 8'h01);
	endtask

	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		rchk("control", la(3, UPDATE_CONTROL_INDEX), UPDATE_CONTROL_RESET);
		rchk("flags", la(3, OVERFLOW_FLAGS_LOW_INDEX), OVERFLOW_FLAGS_RESET);
		wr(la(3, OVERFLOW_ENABLE_HIGH_INDEX), 8'hff);
		chk("write resp", {30'h0, RESP_OKAY}, {30'h0, wr_resp});
		wr(la(3, OVERFLOW_ENABLE_LOW_INDEX), 8'hff);
		rchk("enable high", la(3, OVERFLOW_ENABLE_HIGH_INDEX), HIGH_GROUP_MASK);
		rchk("enable low", la(3, OVERFLOW_ENABLE_LOW_INDEX), LOW_GROUP_MASK);
		rchk("other link", la(2, OVERFLOW_ENABLE_LOW_INDEX), 8'h00);
		chk("irq", 32'h0, {31'h0, irq});
		wr(la(3, OVERFLOW_ENABLE_HIGH_INDEX), 8'h00);
		wr(la(3, OVERFLOW_ENABLE_LOW_INDEX), 8'h00);
		rd(la(0, 8'hc7), d, r);
		chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
		chk("unmapped data", 32'h0, d);
		$display("done registers");
	endtask

	task automatic t_manual();
		pulse(0, LC, 258);
		pulse(0, CK, 2);
		pulse(0, FB, 257);
		pulse(0, AL, 1);
		pulse(0, SY, 2);
		pulse(0, PT, 4);
		pulse(1, LC, 5);
		trig(0);
		hchk(0, HOLD_LINE_CODE_LOW, 8'h02);
		hchk(0, HOLD_LINE_CODE_HIGH, 8'h01);
		hchk(0, HOLD_CHECKSUM_LOW, 8'h02);
		hchk(0, HOLD_FRAMING_LOW, 8'h01);
		hchk(0, HOLD_FRAMING_HIGH, 8'h01);
		hchk(0, HOLD_ALIGNMENT, 8'h01);
		hchk(0, HOLD_SYNC_LOSS, 8'h02);
		hchk(0, HOLD_PATTERN_LOW, 8'h04);
		hchk(1, HOLD_LINE_CODE_LOW, 8'h00);
		trig(1);
		hchk(1, HOLD_LINE_CODE_LOW, 8'h05);
		trig(0);
		hchk(0, HOLD_LINE_CODE_LOW, 8'h00);
		$display("done manual transfer");
	endtask

	task automatic t_format();
		pulse(2, CK, 2);
		pulse(2, FB, 1);
		pulse(3, DD, 3);
		pulse(3, CK, 1);
		pulse(1, DD, 2);
		pulse(0, DD, 1);
		trig(2);
		trig(3);
		trig(1);
		trig(0);
		hchk(2, HOLD_CHECKSUM_LOW, 8'h00);
		hchk(2, HOLD_FRAMING_LOW, 8'h01);
		hchk(3, HOLD_DDS_LOW, 8'h03);
		hchk(3, HOLD_CHECKSUM_LOW, 8'h00);
		hchk(1, HOLD_DDS_LOW, 8'h00);
		hchk(0, HOLD_DDS_LOW, 8'h00);
		$display("done formats");
	endtask

	task automatic t_overflow();
		pulse(0, AL, 8);
		repeat (4) @(posedge aclk);
		chk("irq masked", 32'h0, {31'h0, irq});
		rchk("flags", la(0, OVERFLOW_FLAGS_LOW_INDEX), 8'h04);
		wr(la(0, OVERFLOW_ENABLE_LOW_INDEX), 8'h04);
		repeat (4) @(posedge aclk);
		chk("irq enabled", 32'h1, {31'h0, irq});
		wr(la(0, OVERFLOW_FLAGS_LOW_INDEX), 8'h04);
		repeat (4) @(posedge aclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		rchk("flags", la(0, OVERFLOW_FLAGS_LOW_INDEX), 8'h00);
		wr(la(0, OVERFLOW_ENABLE_LOW_INDEX), 8'h00);
		wr(la(0, OVERFLOW_ENABLE_HIGH_INDEX), 8'h01);
		pulse(0, SY, 32);
		repeat (4) @(posedge aclk);
		rchk("flags", la(0, OVERFLOW_FLAGS_LOW_INDEX), 8'h08);
		chk("irq wrong group", 32'h0, {31'h0, irq});
		$display("done overflow");
	endtask

	task automatic t_auto();
		logic [31:0] d;
		logic [1:0] r;
		int n;
		wr(la(2, UPDATE_CONTROL_INDEX), 8'h02);
		pulse(2, PT, 1);
		wr(sel_a, {4'h2, HOLD_PATTERN_LOW});
		n = 0;
		do
		begin
			rd(dat_a, d, r);
			n++;
		end
		while (d !== 32'h1 && n < 40);
		chk("auto holding", 32'h1, d);
		repeat (SEC + 5) @(posedge aclk);
		rchk("next interval", dat_a, 8'h00);
		wr(la(2, UPDATE_CONTROL_INDEX), 8'h00);
		$display("done auto transfer");
	endtask

	// Transfer lands inside a burst of events; the two intervals must share every one
	task automatic t_overlap();
		logic [31:0] d;
		logic [31:0] e;
		logic [1:0] r;
		fork
			pulse(3, LC, 20);
			trig(3);
		join
		wr(sel_a, {4'h3, HOLD_LINE_CODE_LOW});
		rd(dat_a, d, r);
		trig(3);
		rd(dat_a, e, r);
		chk("split count", 32'd20, d + e);
		$display("done transfer overlap");
	endtask

	initial
	begin
		for (int i = 0; i < LINK_COUNT; i++)
		begin
			link_events[i] = '0;
		end
		framing_format[0] = extended_superframe_format;
		framing_format[1] = digital_data_framing_format;
		framing_format[2] = superframe_format;
		framing_format[3] = digital_data_framing_format;
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		t_regs();
		t_manual();
		t_format();
		t_overflow();
		t_auto();
		t_overlap();
		finish_test();
	end
endmodule // pmc_performance_monitor_tb_top

`default_nettype wire
